// [design/pmsp_status_page.v]
// Purpose: T1 receive performance monitor status page
// Assumes: framer events are one-cycle pulses synchronous to CLK_SYS
// Notes:   host port is a simple read/write strobe on a 5-bit page address
`timescale 1ns/100ps
`default_nettype none
`include "pmsp_map.vh"
module pmsp_status_page (
  // clock and reset
  input  wire       CLK_SYS,
  input  wire       RST,
  // host port
  input  wire [4:0] HOST_ADDR,
  input  wire       HOST_RD,
  input  wire       HOST_WR,
  input  wire [7:0] HOST_WDATA,
  output reg  [7:0] HOST_RDATA,
  // framer mode
  input  wire       ESF_MODE,
  input  wire       D4_CHECK_FS,
  input  wire       FRAME_SYNC,
  // framing bit errors by kind
  input  wire       ESF_FBIT_ERR,
  input  wire       FT_BIT_ERR,
  input  wire       FS_BIT_ERR,
  // counted events
  input  wire       PRBS_ERR,
  input  wire       CRC_MULTIFRAME,
  input  wire       FRAME_LOST,
  input  wire       RESYNC_DONE,
  input  wire       ALIGN_SHIFTED,
  input  wire       MF_SYNC_LOST,
  input  wire       BPV_ERR,
  input  wire       CRC6_ERR,
  // alarm events
  input  wire       D4_ALARM_LONG,
  input  wire       D4_ALARM_SHORT,
  input  wire       ALT_ALARM,
  input  wire       ESF_ALARM,
  input  wire       ALL_ONES,
  input  wire       DENSITY_VIOL,
  input  wire       LOOP_UP_CODE,
  input  wire       LOOP_DOWN_CODE,
  // interrupt sources, word zero
  input  wire [7:0] IRQ0_EVENTS,
  input  wire [7:0] IRQ0_MASK,
  // interrupt words kept by other logic
  input  wire [7:0] IRQ1_WORD,
  input  wire [7:0] IRQ2_WORD,
  input  wire [7:0] IRQ3_WORD,
  // read-clear strobes for those words
  output reg        IRQ1_RD,
  output reg        IRQ2_RD,
  output reg        IRQ3_RD
);
  // ****************************************************
  // address decode
  // ****************************************************
  function hit;
    input [4:0] a;
    input [4:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // upper byte of a sixteen-bit tally; bytes are read without a snapshot,
  // so software that wants a coherent value reads twice and compares
  function [7:0] hi_byte;
    input [15:0] w;
    begin
      hi_byte = w[15:8];
    end
  endfunction

  // lower byte of a sixteen-bit tally
  function [7:0] lo_byte;
    input [15:0] w;
    begin
      lo_byte = w[7:0];
    end
  endfunction

  wire rd_alarm = HOST_RD & hit(HOST_ADDR, `PMSP_OFS_ALARM);
  wire rd_irq0  = HOST_RD & hit(HOST_ADDR, `PMSP_OFS_IRQ0);
  wire rd_ovf   = HOST_RD & hit(HOST_ADDR, `PMSP_OFS_OVF);
  wire wr_prbs  = HOST_WR & hit(HOST_ADDR, `PMSP_OFS_PRBS_ERR);

  // ****************************************************
  // framing error qualification
  // ****************************************************
  // select checked bits by format
  wire fbit_err = ESF_MODE ? ESF_FBIT_ERR :
                  (FT_BIT_ERR | (D4_CHECK_FS & FS_BIT_ERR));
  wire frm_inc  = fbit_err & FRAME_SYNC;
  // shift only on resync at new position
  wire shift_inc = RESYNC_DONE & ALIGN_SHIFTED;

  // ****************************************************
  // tallies
  // ****************************************************
  wire [7:0]  prbs_cnt;
  wire [7:0]  prbs_mf_cnt;
  wire [7:0]  frm_cnt;
  wire [3:0]  loss_cnt;
  wire [3:0]  shift_cnt;
  wire [7:0]  mfloss_cnt;
  wire [15:0] bpv_cnt;
  wire [15:0] crc_cnt;
  wire        prbs_ovf;
  wire        frm_ovf;
  wire        loss_ovf;
  wire        shift_ovf;
  wire        mfloss_ovf;
  wire        bpv_ovf;
  wire        crc_ovf;

  // tallies hold at full scale rather than wrap, so a read never shows a
  // small count after a flood of errors; the overflow latch says it happened for every tally but the prbs multiframe one
  // prbs mismatch tally
  pmsp_tally #(.W(8)) u_prbs (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .inc     (PRBS_ERR),
    .clr     (wr_prbs),
    .cnt_q   (prbs_cnt),
    .ovf     (prbs_ovf)
  );
  pmsp_tally #(.W(8)) u_prbs_mf (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .inc     (CRC_MULTIFRAME),
    .clr     (wr_prbs),
    .cnt_q   (prbs_mf_cnt),
    .ovf     ()
  );
  pmsp_tally #(.W(8)) u_frm (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .inc     (frm_inc),
    .clr     (1'b0),
    .cnt_q   (frm_cnt),
    .ovf     (frm_ovf)
  );
  pmsp_tally #(.W(4)) u_loss (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .inc     (FRAME_LOST),
    .clr     (1'b0),
    .cnt_q   (loss_cnt),
    .ovf     (loss_ovf)
  );
  pmsp_tally #(.W(4)) u_shift (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .inc     (shift_inc),
    .clr     (1'b0),
    .cnt_q   (shift_cnt),
    .ovf     (shift_ovf)
  );
  pmsp_tally #(.W(8)) u_mfloss (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .inc     (MF_SYNC_LOST),
    .clr     (1'b0),
    .cnt_q   (mfloss_cnt),
    .ovf     (mfloss_ovf)
  );
  pmsp_tally #(.W(16)) u_bpv (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .inc     (BPV_ERR),
    .clr     (1'b0),
    .cnt_q   (bpv_cnt),
    .ovf     (bpv_ovf)
  );
  pmsp_tally #(.W(16)) u_crc (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .inc     (CRC6_ERR),
    .clr     (1'b0),
    .cnt_q   (crc_cnt),
    .ovf     (crc_ovf)
  );

  // ****************************************************
  // sticky latches
  // ****************************************************
  wire [7:0] alarm_lat;
  wire [7:0] irq0_lat;
  wire [7:0] ovf_lat;
  wire [7:0] alarm_set;
  wire [7:0] irq0_set;
  wire [7:0] ovf_set;

  assign alarm_set[7] = D4_ALARM_LONG;
  assign alarm_set[6] = D4_ALARM_SHORT;
  assign alarm_set[5] = ALT_ALARM;
  assign alarm_set[4] = ESF_ALARM;
  assign alarm_set[3] = ALL_ONES;
  assign alarm_set[2] = DENSITY_VIOL;
  assign alarm_set[1] = LOOP_UP_CODE;
  assign alarm_set[0] = LOOP_DOWN_CODE;

  assign irq0_set = IRQ0_EVENTS & ~IRQ0_MASK & 8'hdf;

  assign ovf_set[`PMSP_OVF_FRM]    = frm_ovf;
  assign ovf_set[`PMSP_OVF_CRC]    = crc_ovf;
  assign ovf_set[`PMSP_OVF_LOSS]   = loss_ovf;
  assign ovf_set[`PMSP_OVF_SHIFT]  = shift_ovf;
  assign ovf_set[`PMSP_OVF_BPV]    = bpv_ovf;
  assign ovf_set[`PMSP_OVF_PRBS]   = prbs_ovf;
  assign ovf_set[`PMSP_OVF_MFLOSS] = mfloss_ovf;
  assign ovf_set[0]                = 1'b0;

  pmsp_latch u_alarm (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .set     (alarm_set),
    .rd_clr  (rd_alarm),
    .lat_q   (alarm_lat)
  );
  pmsp_latch u_irq0 (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .set     (irq0_set),
    .rd_clr  (rd_irq0),
    .lat_q   (irq0_lat)
  );
  pmsp_latch u_ovf (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .set     (ovf_set),
    .rd_clr  (rd_ovf),
    .lat_q   (ovf_lat)
  );

  // ****************************************************
  // clear strobes for the words kept outside
  // ****************************************************
  // next values of the registered strobes; registering them gives the
  // outside logic a clean one-cycle pulse at the cost of one cycle delay
  wire [2:0] irq_rd_d;

  assign irq_rd_d[0] = HOST_RD & hit(HOST_ADDR, `PMSP_OFS_IRQ1);
  assign irq_rd_d[1] = HOST_RD & hit(HOST_ADDR, `PMSP_OFS_IRQ2);
  assign irq_rd_d[2] = HOST_RD & hit(HOST_ADDR, `PMSP_OFS_IRQ3);

  // ****************************************************
  // read mux
  // ****************************************************
  reg [7:0] rdata_d;
  // unused and unknown offsets read zero
  always @*
  begin
    rdata_d = `PMSP_RST_BYTE;
    case (HOST_ADDR)
      `PMSP_OFS_PRBS_ERR:   rdata_d = prbs_cnt;
      `PMSP_OFS_PRBS_MF:    rdata_d = prbs_mf_cnt;
      `PMSP_OFS_ALARM:      rdata_d = alarm_lat;
      `PMSP_OFS_FRM_ERR:    rdata_d = frm_cnt;
      `PMSP_OFS_LOSS_SHIFT: rdata_d = {loss_cnt, shift_cnt};
      `PMSP_OFS_MF_LOSS:    rdata_d = mfloss_cnt;
      `PMSP_OFS_BPV_HI:     rdata_d = hi_byte(bpv_cnt);
      `PMSP_OFS_BPV_LO:     rdata_d = lo_byte(bpv_cnt);
      `PMSP_OFS_CRC_HI:     rdata_d = hi_byte(crc_cnt);
      `PMSP_OFS_CRC_LO:     rdata_d = lo_byte(crc_cnt);
      `PMSP_OFS_IRQ0:       rdata_d = irq0_lat;
      `PMSP_OFS_IRQ1:       rdata_d = IRQ1_WORD;
      `PMSP_OFS_IRQ2:       rdata_d = IRQ2_WORD;
      `PMSP_OFS_IRQ3:       rdata_d = IRQ3_WORD;
      `PMSP_OFS_OVF:        rdata_d = ovf_lat;
      default:              rdata_d = `PMSP_RST_BYTE;
    endcase
  end

  // registered data, captured on the read strobe before the clear lands
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      HOST_RDATA <= `PMSP_RST_BYTE;
      IRQ1_RD    <= 1'b0;
      IRQ2_RD    <= 1'b0;
      IRQ3_RD    <= 1'b0;
    end
    else
    begin
      if (HOST_RD)
        HOST_RDATA <= rdata_d;
      // strobes stand exactly one cycle
      IRQ1_RD <= irq_rd_d[0];
      IRQ2_RD <= irq_rd_d[1];
      IRQ3_RD <= irq_rd_d[2];
    end
  end
endmodule
`default_nettype wire

// [design/pmsp_map.vh]
// Purpose: offsets, field positions and reset values of the status page
// Assumes: 5-bit page address, 8-bit data
// Notes:   included by the status page and latch design files
`ifndef PMSP_MAP_VH
`define PMSP_MAP_VH
// ****************************************************
// register offsets
// ****************************************************
`define PMSP_OFS_PRBS_ERR    5'h10
`define PMSP_OFS_PRBS_MF     5'h11
`define PMSP_OFS_ALARM       5'h12
`define PMSP_OFS_FRM_ERR     5'h13
`define PMSP_OFS_LOSS_SHIFT  5'h14
`define PMSP_OFS_MF_LOSS     5'h15
`define PMSP_OFS_BPV_HI      5'h16
`define PMSP_OFS_BPV_LO      5'h17
`define PMSP_OFS_CRC_HI      5'h18
`define PMSP_OFS_CRC_LO      5'h19
`define PMSP_OFS_SPARE       5'h1a
`define PMSP_OFS_IRQ0        5'h1b
`define PMSP_OFS_IRQ1        5'h1c
`define PMSP_OFS_IRQ2        5'h1d
`define PMSP_OFS_IRQ3        5'h1e
`define PMSP_OFS_OVF         5'h1f
// ****************************************************
// interrupt word zero bit positions
// ****************************************************
`define PMSP_IRQ_FSYNC       7
`define PMSP_IRQ_MFSYNC      6
`define PMSP_IRQ_AIS         4
`define PMSP_IRQ_LOS         3
`define PMSP_IRQ_SEF         2
`define PMSP_IRQ_TXSLIP      1
`define PMSP_IRQ_RXSLIP      0
// ****************************************************
// overflow latch bit positions
// ****************************************************
`define PMSP_OVF_FRM         7
`define PMSP_OVF_CRC         6
`define PMSP_OVF_LOSS        5
`define PMSP_OVF_SHIFT       4
`define PMSP_OVF_BPV         3
`define PMSP_OVF_PRBS        2
`define PMSP_OVF_MFLOSS      1
// ****************************************************
// reset values
// ****************************************************
`define PMSP_RST_BYTE        8'h00
`define PMSP_RST_WORD        16'h0000
`define PMSP_RST_NIB         4'h0
`endif

// [design/pmsp_tally.v]
// Purpose: saturating event tally with overflow pulse and clear
// Assumes: one event per clock at most
// Notes:   holds at full scale so software sees a bounded count
`timescale 1ns/100ps
`default_nettype none
module pmsp_tally #(
  parameter W = 8
) (
  // clock and reset
  input  wire         CLK_SYS,
  input  wire         RST,
  // control
  input  wire         inc,
  input  wire         clr,
  // state
  output reg  [W-1:0] cnt_q,
  output wire         ovf
);
  // ****************************************************
  // counter
  // ****************************************************
  wire full = &cnt_q;
  // overflow pulse when an event meets a full tally
  assign ovf = inc & full & ~clr;
  // clear wins, then count, hold at full scale
  always @(posedge CLK_SYS)
  begin
    if (RST)
      cnt_q <= {W{1'b0}};
    else if (clr)
      cnt_q <= {W{1'b0}};
    else if (inc && !full)
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
  end
endmodule
`default_nettype wire

// [design/pmsp_latch.v]
// Purpose: byte of sticky latches, cleared by a host read
// Assumes: read strobe is a single-cycle pulse
// Notes:   a set arriving with the clearing read survives
`timescale 1ns/100ps
`default_nettype none
`include "pmsp_map.vh"
module pmsp_latch (
  // clock and reset
  input  wire       CLK_SYS,
  input  wire       RST,
  // control
  input  wire [7:0] set,
  input  wire       rd_clr,
  // state
  output reg  [7:0] lat_q
);
  // ****************************************************
  // sticky bits
  // ****************************************************
  // set wins over the read clear so no event is lost
  always @(posedge CLK_SYS)
  begin
    if (RST)
      lat_q <= `PMSP_RST_BYTE;
    else if (rd_clr)
      lat_q <= set;
    else
      lat_q <= lat_q | set;
  end
endmodule
`default_nettype wire

// [tb/pmsp_status_page_assertions.sv]
// Purpose: concurrent checks on the status page host port
// Assumes: one clock, synchronous active-high reset
// Notes:   sees top ports only; bound after the module
`timescale 1ns/100ps
`default_nettype none
module pmsp_chk (
  // clock and reset
  input wire logic       CLK_SYS,
  input wire logic       RST,
  // host port
  input wire logic [4:0] HOST_ADDR,
  input wire logic       HOST_RD,
  input wire logic       HOST_WR,
  input wire logic [7:0] HOST_RDATA,
  // watched inputs and strobe
  input wire logic       FRAME_SYNC,
  input wire logic       CRC_MULTIFRAME,
  input wire logic       LOOP_UP_CODE,
  input wire logic       IRQ1_RD
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  // one-hot read decode, so each check names its offset
  wire [31:0] hit = HOST_RD ? (32'h1 << HOST_ADDR) : 32'h0;
  wire        wr10 = HOST_WR && (HOST_ADDR == 5'h10);
  // read data is registered, so results show one edge later
  spare_read_a: assert property (hit[5'h1a] |=> HOST_RDATA == 8'h00)
    else $error("spare offset read nonzero");
  irq_gap_a: assert property (hit[5'h1b] |=> !HOST_RDATA[5])
    else $error("unused interrupt bit set");
  ovf_gap_a: assert property (hit[5'h1f] |=> !HOST_RDATA[0])
    else $error("unused overflow bit set");
  irq_strobe_a: assert property (hit[5'h1c] ##1 !hit[5'h1c] |-> IRQ1_RD ##1 !IRQ1_RD)
    else $error("word one clear strobe wrong");
  loop_set_a: assert property (LOOP_UP_CODE ##1 !hit[5'h12] ##1 hit[5'h12] |=> HOST_RDATA[1])
    else $error("loop up latch not set");
  loop_clear_a: assert property (hit[5'h12] && !LOOP_UP_CODE ##1 !LOOP_UP_CODE
    ##1 hit[5'h12] |=> !HOST_RDATA[1])
    else $error("loop up latch not cleared");
  frm_frozen_a: assert property (hit[5'h13] && !FRAME_SYNC ##1 !FRAME_SYNC ##1 hit[5'h13]
    |=> HOST_RDATA == $past(HOST_RDATA, 2))
    else $error("framing tally moved out of sync");
  prbs_clear_a: assert property (wr10 ##1 !CRC_MULTIFRAME ##1 hit[5'h11]
    |=> HOST_RDATA == 8'h00)
    else $error("multiframe tally not cleared");
  // main scenarios reached
  cover property (hit[5'h12]);
  cover property (wr10);
  cover property (hit[5'h1b]);
endmodule
bind pmsp_status_page pmsp_chk u_chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .HOST_ADDR(HOST_ADDR), .HOST_RD(HOST_RD),
  .HOST_WR(HOST_WR), .HOST_RDATA(HOST_RDATA), .FRAME_SYNC(FRAME_SYNC),
  .CRC_MULTIFRAME(CRC_MULTIFRAME), .LOOP_UP_CODE(LOOP_UP_CODE), .IRQ1_RD(IRQ1_RD)
);
`default_nettype wire

// [tb/pmsp_status_page_tb.sv]
// Purpose: self-checking bench for the status page
// Assumes: 10 MHz clock, inputs change on the falling edge
// Notes:   framing tally is driven to full scale to see it hold
`timescale 1ns/100ps
`default_nettype none
module pmsp_status_page_tb;
  // ********
  // stimulus
  // ********
  logic       clk, rst, rd, wr, esf, fsc, fsy, shf;
  logic [4:0] adr;
  logic [7:0] rdat, al, ie, im, w1, w2, w3;
  logic [9:0] ev;
  logic [2:0] irs;
  int         n_mismatch, n_checks;
  pmsp_status_page DUT (
    .CLK_SYS(clk), .RST(rst), .HOST_ADDR(adr), .HOST_RD(rd), .HOST_WR(wr),
    .HOST_WDATA(8'hff), .HOST_RDATA(rdat), .ESF_MODE(esf), .D4_CHECK_FS(fsc),
    .FRAME_SYNC(fsy), .ESF_FBIT_ERR(ev[7]), .FT_BIT_ERR(ev[8]), .FS_BIT_ERR(ev[9]),
    .PRBS_ERR(ev[0]), .CRC_MULTIFRAME(ev[1]), .FRAME_LOST(ev[2]), .RESYNC_DONE(ev[3]),
    .ALIGN_SHIFTED(shf), .MF_SYNC_LOST(ev[4]), .BPV_ERR(ev[5]), .CRC6_ERR(ev[6]),
    .D4_ALARM_LONG(al[7]), .D4_ALARM_SHORT(al[6]), .ALT_ALARM(al[5]), .ESF_ALARM(al[4]),
    .ALL_ONES(al[3]), .DENSITY_VIOL(al[2]), .LOOP_UP_CODE(al[1]), .LOOP_DOWN_CODE(al[0]),
    .IRQ0_EVENTS(ie), .IRQ0_MASK(im), .IRQ1_WORD(w1), .IRQ2_WORD(w2), .IRQ3_WORD(w3),
    .IRQ1_RD(irs[0]), .IRQ2_RD(irs[1]), .IRQ3_RD(irs[2])
  );
  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // one-cycle read, data compared once it has landed
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    @(negedge clk);
    rd = 1'b1;
    adr = a;
    @(negedge clk);
    rd = 1'b0;
    n_checks++;
    if (rdat !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t read %h got %h want %h", $time, a, rdat, e);
    end
  endtask
  // one-cycle write, data is ignored by the page
  task automatic wr_at(input logic [4:0] a);
    @(negedge clk);
    wr = 1'b1;
    adr = a;
    @(negedge clk);
    wr = 1'b0;
  endtask
  // clear strobes stand one cycle, so look before the next edge
  task automatic irs_chk(input logic [2:0] e);
    n_checks++;
    if (irs !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t clear strobes %b want %b", $time, irs, e);
    end
  endtask
  // events held n cycles count once per cycle
  task automatic pulse(input logic [17:0] m, input int n);
    @(negedge clk);
    {al, ev} = m;
    repeat (n) @(negedge clk);
    {al, ev} = 18'h0;
  endtask
  task automatic t_reset;
    for (int i = 16; i < 32; i++) rd_chk(i[4:0], 8'h00);
    rd_chk(5'h05, 8'h00);
  endtask
  task automatic t_prbs;
    pulse(18'h001, 5);
    pulse(18'h002, 3);
    rd_chk(5'h10, 8'h05);
    rd_chk(5'h11, 8'h03);
    wr_at(5'h10);
    rd_chk(5'h11, 8'h00);
    rd_chk(5'h10, 8'h00);
  endtask
  task automatic t_alarm;
    for (int i = 0; i < 8; i++)
    begin
      pulse(18'h400 << i, 1);
      rd_chk(5'h12, 8'h01 << i);
      rd_chk(5'h12, 8'h00);
    end
  endtask
  task automatic t_frm;
    fsy = 1'b1;
    esf = 1'b1;
    pulse(18'h080, 2);
    pulse(18'h100, 1);
    esf = 1'b0;
    pulse(18'h380, 1);
    fsc = 1'b1;
    pulse(18'h200, 1);
    fsy = 1'b0;
    pulse(18'h380, 3);
    wr_at(5'h13);
    rd_chk(5'h13, 8'h04);
    rd_chk(5'h13, 8'h04);
  endtask
  task automatic t_loss;
    fsy = 1'b1;
    pulse(18'h004, 3);
    shf = 1'b1;
    pulse(18'h008, 2);
    shf = 1'b0;
    pulse(18'h008, 4);
    rd_chk(5'h14, 8'h32);
    pulse(18'h100, 252);
    rd_chk(5'h13, 8'hff);
    rd_chk(5'h1f, 8'h80);
    rd_chk(5'h1f, 8'h00);
    shf = 1'b1;
    pulse(18'h00c, 14);
    shf = 1'b0;
    rd_chk(5'h14, 8'hff);
    rd_chk(5'h1f, 8'h30);
  endtask
  task automatic t_wide;
    pulse(18'h010, 7);
    pulse(18'h060, 258);
    pulse(18'h020, 3);
    rd_chk(5'h15, 8'h07);
    rd_chk(5'h16, 8'h01);
    rd_chk(5'h17, 8'h05);
    rd_chk(5'h18, 8'h01);
    rd_chk(5'h19, 8'h02);
    rd_chk(5'h1a, 8'h00);
    pulse(18'h011, 256);
    rd_chk(5'h10, 8'hff);
    rd_chk(5'h15, 8'hff);
    rd_chk(5'h1f, 8'h06);
  endtask
  task automatic t_irq;
    im = 8'h02;
    w1 = 8'ha5;
    w2 = 8'h3c;
    w3 = 8'h81;
    @(negedge clk);
    ie = 8'hff;
    @(negedge clk);
    ie = 8'h00;
    rd_chk(5'h1b, 8'hdd);
    rd_chk(5'h1b, 8'h00);
    irs_chk(3'b000);
    rd_chk(5'h1c, 8'ha5);
    irs_chk(3'b001);
    rd_chk(5'h1d, 8'h3c);
    irs_chk(3'b010);
    rd_chk(5'h1e, 8'h81);
    irs_chk(3'b100);
  endtask
  // verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {rd, wr, esf, fsc, fsy, shf, adr, al, ev, ie, im, w1, w2, w3} = '0;
    n_mismatch = 0;
    n_checks = 0;
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_prbs();
    t_alarm();
    t_frm();
    t_loss();
    t_wide();
    t_irq();
    summarize();
  end
  // watchdog, far beyond the expected run
  initial
  begin
    #1000000;
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
